// >>> core/protection_fault_pkg.sv
package protection_fault_pkg;
  localparam int CLK_PERIOD_NS = 4;
  localparam int ADDR_W = 12;
  localparam int BLANK_W = 12;
  // Register indexes; byte address is four times the index
  localparam logic [7:0] IDX_LATCH_CFG = 8'h4D;
  localparam logic [7:0] IDX_WAKE_CFG = 8'h4E;
  localparam logic [7:0] IDX_DISABLE_CFG = 8'h4F;
  localparam logic [7:0] IDX_BLANK_CFG = 8'h50;
  localparam logic [11:0] ADDR_STATUS = 12'h200;
  localparam logic [11:0] ADDR_MASK = 12'h204;
  localparam logic [11:0] ADDR_RESTART = 12'h208;
  localparam logic [11:0] ADDR_STATE = 12'h20C;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] WMASK_LATCH = 8'h03;
  localparam logic [7:0] WMASK_WAKE = 8'h0F;
  localparam logic [7:0] WMASK_RESTART = 8'hFE;
  // Field positions
  localparam int LAT_BIT = 1;
  localparam int MAXP_BIT = 0;
  localparam int OCP_OFF_BIT = 7;
  localparam int OLP_OFF_BIT = 6;
  localparam int OVP_OFF_BIT = 5;
  localparam int BOOST_OV_OFF_BIT = 4;
  localparam int CLAMP_OFF_BIT = 3;
  localparam int LINE_LINK_OFF_BIT = 2;
  localparam int EXT_OFF_BIT = 1;
  localparam int INT_OT_OFF_BIT = 0;
  localparam int SAMP_BIT = 0;
  localparam int RST_SLOW_BIT = 1;
  // Status bits
  localparam int EV_W = 5;
  localparam int EV_S2_FAULT = 0;
  localparam int EV_LATCH = 1;
  localparam int EV_EXT_OT = 2;
  localparam int EV_INT_OT = 3;
  localparam int EV_BOOST = 4;
  // Times and derived cycle counts
  localparam int OCP_BASE_NS = 150;
  localparam int OCP_STEP_NS = 50;
  localparam int OLP_BASE_NS = 1000;
  localparam int OLP_STEP_NS = 500;
  localparam int RESTART_FAST_NS = 25600;
  localparam int RESTART_SLOW_NS = 40960000;
  localparam int SAMPLE_FAST_NS = 10000;
  localparam int SAMPLE_SLOW_NS = 1000000;
  localparam int RESTART_FAST_CYC = RESTART_FAST_NS / CLK_PERIOD_NS;
  localparam int RESTART_SLOW_CYC = RESTART_SLOW_NS / CLK_PERIOD_NS;
  localparam int SAMPLE_FAST_CYC = SAMPLE_FAST_NS / CLK_PERIOD_NS;
  localparam int SAMPLE_SLOW_CYC = SAMPLE_SLOW_NS / CLK_PERIOD_NS;
  localparam logic [7:0] SHDN_OFFSET = 8'h10;

  typedef enum logic [2:0] {
    S2_RUN = 3'b001,
    S2_WAIT = 3'b010,
    S2_LATCH = 3'b100
  } s2_state_e;

  function automatic logic [11:0] byte_addr(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction : byte_addr

  function automatic logic [11:0] blank_cycles(input int base, input int step,
                                               input logic [3:0] n);
    return 12'((base + step * int'(n) + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  endfunction : blank_cycles

  function automatic logic [7:0] sat_add(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[8] ? 8'hFF : s[7:0];
  endfunction : sat_add
endpackage : protection_fault_pkg

// >>> core/blank_if.sv
`timescale 1ns/10ps
interface blank_if;
  logic start;
  logic [11:0] cycles;
  logic active;
  modport ctrl (output start, output cycles, input active);
  modport timer (input start, input cycles, output active);
endinterface : blank_if

// >>> core/blank_timer.sv
`timescale 1ns/10ps
module blank_timer (
  input wire logic hclk,
  input wire logic hresetn,
  blank_if.timer blank
);
  typedef struct packed {
    logic [11:0] cnt;
  } blank_st_s;

  blank_st_s q;
  blank_st_s d;

  // Blank window counts from the start pulse
  always_comb begin
    d = q;
    if (blank.start) begin
      d.cnt = blank.cycles - 12'h001;
    end else if (q.cnt != 12'h000) begin
      d.cnt = q.cnt - 12'h001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign blank.active = blank.start | (q.cnt != 12'h000);

  a_blank_load: assert property (@(posedge hclk) disable iff (!hresetn)
    blank.start |=> q.cnt == $past(blank.cycles) - 12'h001)
    else $error("blank counter not loaded");
  a_blank_run: assert property (@(posedge hclk) disable iff (!hresetn)
    (q.cnt > 12'h001) && !blank.start |=> blank.active && q.cnt == $past(q.cnt) - 12'h001)
    else $error("blank window ended early");
endmodule : blank_timer

// >>> core/protection_fault_config.sv
`timescale 1ns/10ps
// Functional notes
// - Latch select bit makes diff-voltage fault latched
// - Max-power bit: boost overvoltage forces stage2 power
// - Power-up in external overtemp unless below wake-up
// - Below wake-up code clears all overtemp faults
// - Wake-up code is threshold plus four times field
// - Shutdown code sits above wake-up code
// - Bits 7..5 disable overcurrent, open-loop, output overvoltage
// - Bits 4..2 disable boost, clamp, line-link protection
// - Bits 1..0 disable external and internal overtemp
// - Overcurrent blanked 150 ns plus 50 ns steps
// - Open-loop blanked 1 us plus 0.5 us steps
// - Sample bit selects slow internal temperature sampling while no internal overtemp
// - Unlatched stage2 faults restart after field times unit
module protection_fault_config #(
  parameter int RESTART_FAST = protection_fault_pkg::RESTART_FAST_CYC,
  parameter int RESTART_SLOW = protection_fault_pkg::RESTART_SLOW_CYC,
  parameter int SAMPLE_FAST = protection_fault_pkg::SAMPLE_FAST_CYC,
  parameter int SAMPLE_SLOW = protection_fault_pkg::SAMPLE_SLOW_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [7:0] ext_temp_code,
  input wire logic [7:0] external_thermal_threshold,
  input wire logic int_temp_hot,
  input wire logic gate_rise,
  input wire logic vdiff_fault_in,
  input wire logic boost_ov_in,
  input wire logic ocp_in,
  input wire logic olp_in,
  input wire logic ovp_in,
  input wire logic clamp_power_in,
  input wire logic line_link_in,
  output logic boost_en,
  output logic stage2_en,
  output logic stage2_max_power,
  output logic ext_overtemp,
  output logic int_overtemp,
  output logic int_temp_sample,
  output logic irq
);
  localparam logic [11:0] A_LATCH = protection_fault_pkg::byte_addr(
    protection_fault_pkg::IDX_LATCH_CFG);
  localparam logic [11:0] A_WAKE = protection_fault_pkg::byte_addr(
    protection_fault_pkg::IDX_WAKE_CFG);
  localparam logic [11:0] A_DISABLE = protection_fault_pkg::byte_addr(
    protection_fault_pkg::IDX_DISABLE_CFG);
  localparam logic [11:0] A_BLANK = protection_fault_pkg::byte_addr(
    protection_fault_pkg::IDX_BLANK_CFG);

  typedef struct packed {
    logic [7:0] latch_cfg;
    logic [7:0] wake_cfg;
    logic [7:0] dis_cfg;
    logic [7:0] blank_cfg;
    logic [7:0] rst_cfg;
    logic [4:0] status;
    logic [4:0] mask;
    logic [11:0] dp_addr;
    logic dp_wr;
    logic rd_pend;
    logic [31:0] rdata;
    protection_fault_pkg::s2_state_e s2;
    logic [5:0] rst_cnt;
    logic [23:0] unit_cnt;
    logic [23:0] samp_cnt;
    logic ext_ot;
    logic int_ot;
    logic boost_fault;
    logic samp;
    logic max_power;
    logic boost_en;
    logic stage2_en;
    logic irq;
  } st_s;

  st_s q;
  st_s d;

  blank_if ocp_b ();
  blank_if olp_b ();

  logic [7:0] wake_code;
  logic [7:0] shdn_code;
  logic below;
  logic lat_sel;
  logic ocp_det;
  logic olp_det;
  logic ovp_det;
  logic s2_fault;
  logic [23:0] samp_last;
  logic [23:0] unit_last;
  logic [4:0] ev;
  logic [4:0] wclr;
  logic [7:0] wd;

  // Blanking windows start at each gate rising edge
  assign ocp_b.start = gate_rise;
  assign ocp_b.cycles = protection_fault_pkg::blank_cycles(
    protection_fault_pkg::OCP_BASE_NS, protection_fault_pkg::OCP_STEP_NS,
    q.blank_cfg[7:4]);
  assign olp_b.start = gate_rise;
  assign olp_b.cycles = protection_fault_pkg::blank_cycles(
    protection_fault_pkg::OLP_BASE_NS, protection_fault_pkg::OLP_STEP_NS,
    {1'b0, q.blank_cfg[3:1]});

  blank_timer u_ocp_blank (
    .hclk(hclk),
    .hresetn(hresetn),
    .blank(ocp_b.timer)
  );

  blank_timer u_olp_blank (
    .hclk(hclk),
    .hresetn(hresetn),
    .blank(olp_b.timer)
  );

  // Qualified stage2 detections
  assign ocp_det = ocp_in & ~ocp_b.active
    & ~q.dis_cfg[protection_fault_pkg::OCP_OFF_BIT];
  assign olp_det = olp_in & ~olp_b.active
    & ~q.dis_cfg[protection_fault_pkg::OLP_OFF_BIT];
  assign ovp_det = ovp_in & ~q.dis_cfg[protection_fault_pkg::OVP_OFF_BIT];
  assign s2_fault = ocp_det | olp_det | ovp_det | vdiff_fault_in;
  assign lat_sel = q.latch_cfg[protection_fault_pkg::LAT_BIT];

  // Temperature thresholds
  assign wake_code = protection_fault_pkg::sat_add(external_thermal_threshold,
    {2'b00, q.wake_cfg[3:0], 2'b00});
  assign shdn_code = protection_fault_pkg::sat_add(wake_code,
    protection_fault_pkg::SHDN_OFFSET);
  assign below = ext_temp_code < wake_code;

  assign samp_last = (q.blank_cfg[protection_fault_pkg::SAMP_BIT] && !q.int_ot) ?
    24'(SAMPLE_SLOW - 1) : 24'(SAMPLE_FAST - 1);
  assign unit_last = q.rst_cfg[protection_fault_pkg::RST_SLOW_BIT] ?
    24'(RESTART_SLOW - 1) : 24'(RESTART_FAST - 1);

  always_comb begin
    d = q;
    // Internal temperature sampling
    d.samp = q.samp_cnt >= samp_last;
    d.samp_cnt = d.samp ? 24'h000000 : q.samp_cnt + 24'h000001;
    if (q.samp) begin
      d.int_ot = int_temp_hot;
    end
    // External overtemp entry above shutdown code
    if (q.dis_cfg[protection_fault_pkg::EXT_OFF_BIT]) begin
      d.ext_ot = 1'b0;
    end else if (ext_temp_code > shdn_code) begin
      d.ext_ot = 1'b1;
    end
    if (below) begin
      d.ext_ot = 1'b0;
      d.int_ot = 1'b0;
    end
    if (q.dis_cfg[protection_fault_pkg::INT_OT_OFF_BIT]) begin
      d.int_ot = 1'b0;
    end
    // Boost stage protections
    d.boost_fault = (boost_ov_in & ~q.dis_cfg[protection_fault_pkg::BOOST_OV_OFF_BIT])
      | (clamp_power_in & ~q.dis_cfg[protection_fault_pkg::CLAMP_OFF_BIT])
      | (line_link_in & ~q.dis_cfg[protection_fault_pkg::LINE_LINK_OFF_BIT]);
    d.max_power = q.latch_cfg[protection_fault_pkg::MAXP_BIT] & boost_ov_in
      & ~q.dis_cfg[protection_fault_pkg::BOOST_OV_OFF_BIT];
    // Stage2 fault and restart sequencing
    case (q.s2)
      protection_fault_pkg::S2_RUN: begin
        if (vdiff_fault_in && lat_sel) begin
          d.s2 = protection_fault_pkg::S2_LATCH;
        end else if (s2_fault) begin
          d.s2 = protection_fault_pkg::S2_WAIT;
          d.rst_cnt = q.rst_cfg[7:2];
          d.unit_cnt = 24'h000000;
        end
      end
      protection_fault_pkg::S2_WAIT: begin
        if (vdiff_fault_in && lat_sel) begin
          d.s2 = protection_fault_pkg::S2_LATCH;
        end else if (q.rst_cnt == 6'h00) begin
          d.s2 = protection_fault_pkg::S2_RUN;
        end else if (q.unit_cnt == unit_last) begin
          d.unit_cnt = 24'h000000;
          d.rst_cnt = q.rst_cnt - 6'h01;
        end else begin
          d.unit_cnt = q.unit_cnt + 24'h000001;
        end
      end
      protection_fault_pkg::S2_LATCH: begin
        d.s2 = protection_fault_pkg::S2_LATCH;
      end
      default: begin
        d.s2 = protection_fault_pkg::S2_RUN;
      end
    endcase
    d.boost_en = ~d.ext_ot & ~d.int_ot & ~d.boost_fault;
    d.stage2_en = ~d.ext_ot & ~d.int_ot & (d.s2 == protection_fault_pkg::S2_RUN);
    // Event flags
    ev = '0;
    ev[protection_fault_pkg::EV_S2_FAULT] = (q.s2 == protection_fault_pkg::S2_RUN)
      && (d.s2 != protection_fault_pkg::S2_RUN);
    ev[protection_fault_pkg::EV_LATCH] = (q.s2 != protection_fault_pkg::S2_LATCH)
      && (d.s2 == protection_fault_pkg::S2_LATCH);
    ev[protection_fault_pkg::EV_EXT_OT] = d.ext_ot & ~q.ext_ot;
    ev[protection_fault_pkg::EV_INT_OT] = d.int_ot & ~q.int_ot;
    ev[protection_fault_pkg::EV_BOOST] = d.boost_fault & ~q.boost_fault;
    // Write data phase
    wclr = '0;
    wd = hwdata[7:0];
    if (q.dp_wr) begin
      case (q.dp_addr)
        A_LATCH: d.latch_cfg = wd & protection_fault_pkg::WMASK_LATCH;
        A_WAKE: d.wake_cfg = wd & protection_fault_pkg::WMASK_WAKE;
        A_DISABLE: d.dis_cfg = wd;
        A_BLANK: d.blank_cfg = wd;
        protection_fault_pkg::ADDR_RESTART: begin
          d.rst_cfg = wd & protection_fault_pkg::WMASK_RESTART;
        end
        protection_fault_pkg::ADDR_MASK: d.mask = wd[4:0];
        protection_fault_pkg::ADDR_STATUS: wclr = wd[4:0];
        default: wclr = '0;
      endcase
    end
    // Set wins over write-one clear
    d.status = (q.status & ~wclr) | ev;
    d.irq = |(d.status & d.mask);
    // Read data loaded during the wait cycle
    if (q.rd_pend) begin
      case (q.dp_addr)
        A_LATCH: d.rdata = {24'h000000, q.latch_cfg};
        A_WAKE: d.rdata = {24'h000000, q.wake_cfg};
        A_DISABLE: d.rdata = {24'h000000, q.dis_cfg};
        A_BLANK: d.rdata = {24'h000000, q.blank_cfg};
        protection_fault_pkg::ADDR_RESTART: d.rdata = {24'h000000, q.rst_cfg};
        protection_fault_pkg::ADDR_MASK: d.rdata = {27'h0000000, q.mask};
        protection_fault_pkg::ADDR_STATUS: d.rdata = {27'h0000000, q.status};
        protection_fault_pkg::ADDR_STATE: begin
          d.rdata = {26'h0000000, q.s2, q.ext_ot, q.int_ot, q.boost_fault};
        end
        default: d.rdata = 32'h00000000;
      endcase
    end
    // Address phase capture
    d.dp_wr = 1'b0;
    d.rd_pend = 1'b0;
    if (hsel && htrans[1] && hready) begin
      d.dp_addr = haddr;
      d.dp_wr = hwrite;
      d.rd_pend = ~hwrite;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.latch_cfg <= protection_fault_pkg::CFG_RESET;
      q.s2 <= protection_fault_pkg::S2_RUN;
      q.ext_ot <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign hrdata = q.rdata;
  assign hreadyout = ~q.rd_pend;
  assign hresp = 1'b0;
  assign boost_en = q.boost_en;
  assign stage2_en = q.stage2_en;
  assign stage2_max_power = q.max_power;
  assign ext_overtemp = q.ext_ot;
  assign int_overtemp = q.int_ot;
  assign int_temp_sample = q.samp;
  assign irq = q.irq;

  a_latch_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    q.s2 == protection_fault_pkg::S2_LATCH |=> q.s2 == protection_fault_pkg::S2_LATCH
      && !stage2_en)
    else $error("latched fault released");
  a_unlatch_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    q.s2 == protection_fault_pkg::S2_RUN && vdiff_fault_in && !lat_sel
      |=> q.s2 == protection_fault_pkg::S2_WAIT)
    else $error("unlatched fault not restarting");
  a_max_power: assert property (@(posedge hclk) disable iff (!hresetn)
    q.latch_cfg[0] && boost_ov_in && !q.dis_cfg[4] |=> stage2_max_power)
    else $error("max power not driven");
  a_max_cause: assert property (@(posedge hclk) disable iff (!hresetn)
    !q.latch_cfg[0] |=> !stage2_max_power)
    else $error("max power without enable");
  a_wake_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    below |=> !ext_overtemp && !int_overtemp)
    else $error("overtemp not cleared below wake-up");
  a_wake_code: assert property (@(posedge hclk) disable iff (!hresetn)
    (9'(external_thermal_threshold) + 9'({q.wake_cfg[3:0], 2'b00}) < 9'h100)
      |-> wake_code == external_thermal_threshold + {2'b00, q.wake_cfg[3:0], 2'b00})
    else $error("wake-up code wrong");
  a_code_order: assert property (@(posedge hclk) disable iff (!hresetn)
    wake_code >= external_thermal_threshold && shdn_code >= wake_code)
    else $error("thresholds out of order");
  a_ocp_off: assert property (@(posedge hclk) disable iff (!hresetn)
    q.dis_cfg[7] |-> !ocp_det)
    else $error("overcurrent seen while disabled");
  a_ocp_blank: assert property (@(posedge hclk) disable iff (!hresetn)
    gate_rise |-> !ocp_det ##1 (!ocp_det) [*8])
    else $error("overcurrent inside blank window");
  a_olp_blank: assert property (@(posedge hclk) disable iff (!hresetn)
    gate_rise |-> olp_b.active ##1 olp_b.active [*8])
    else $error("open-loop blank too short");
  a_boost_off: assert property (@(posedge hclk) disable iff (!hresetn)
    q.dis_cfg[4] && q.dis_cfg[3] && q.dis_cfg[2] |=> !q.boost_fault)
    else $error("boost fault while disabled");
  a_ext_off: assert property (@(posedge hclk) disable iff (!hresetn)
    q.dis_cfg[1] |=> !ext_overtemp)
    else $error("external overtemp while disabled");
  a_sample_gap: assert property (@(posedge hclk) disable iff (!hresetn)
    int_temp_sample |=> (!int_temp_sample) [*8])
    else $error("samples too close");
  a_restart_done: assert property (@(posedge hclk) disable iff (!hresetn)
    q.s2 == protection_fault_pkg::S2_WAIT && q.rst_cnt == 6'h00 && !vdiff_fault_in
      |=> q.s2 == protection_fault_pkg::S2_RUN)
    else $error("restart not taken");
  a_reserved_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    q.rd_pend && (q.dp_addr == A_LATCH) |=> hrdata[31:2] == 30'h00000000)
    else $error("reserved bits not zero");

  c_latch: cover property (@(posedge hclk) disable iff (!hresetn)
    q.s2 == protection_fault_pkg::S2_RUN ##1 q.s2 == protection_fault_pkg::S2_LATCH);
  c_restart: cover property (@(posedge hclk) disable iff (!hresetn)
    q.s2 == protection_fault_pkg::S2_WAIT ##1 q.s2 == protection_fault_pkg::S2_RUN);
  c_irq: cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq));
  c_wake: cover property (@(posedge hclk) disable iff (!hresetn) $fell(ext_overtemp));
endmodule : protection_fault_config

// >>> test/protection_fault_config_tb.sv
`timescale 1ns/10ps
module protection_fault_config_tb;
  typedef struct {logic [11:0] a; logic [31:0] wd; logic [31:0] exp;} reg_row_s;
  typedef struct {int src; logic [7:0] blank; int lo; int hi; logic bst;} flt_row_s;
  localparam int S2 = 0;
  localparam int BST = 1;
  localparam int EOT = 2;
  localparam int IOT = 3;
  localparam int IRQ = 4;
  localparam int MAXP = 5;
  localparam int SMP = 6;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [7:0] code = 8'h40;
  logic [7:0] thr = 8'h3C;
  logic hot = 1'b0;
  logic gate = 1'b0;
  logic vdiff = 1'b0;
  logic [5:0] flt = 6'h00;
  logic boost_en, stage2_en, max_pwr, ext_ot, int_ot, samp, irq;
  int num_errors = 0;
  int cmp_count = 0;
  int n;
  logic [31:0] rd;
  reg_row_s regs[7];
  flt_row_s frows[8];

  always #(protection_fault_pkg::CLK_PERIOD_NS / 2) hclk = ~hclk;

  protection_fault_config #(.RESTART_FAST(8), .RESTART_SLOW(16), .SAMPLE_FAST(16),
    .SAMPLE_SLOW(32)) protection_fault_config_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ext_temp_code(code),
    .external_thermal_threshold(thr), .int_temp_hot(hot), .gate_rise(gate),
    .vdiff_fault_in(vdiff), .boost_ov_in(flt[3]), .ocp_in(flt[0]), .olp_in(flt[1]),
    .ovp_in(flt[2]), .clamp_power_in(flt[4]), .line_link_in(flt[5]), .boost_en(boost_en),
    .stage2_en(stage2_en), .stage2_max_power(max_pwr), .ext_overtemp(ext_ot),
    .int_overtemp(int_ot), .int_temp_sample(samp), .irq(irq));

  function automatic logic [11:0] ba(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction : ba

  function automatic logic sig(input int w);
    case (w)
      S2: return stage2_en;
      BST: return boost_en;
      EOT: return ext_ot;
      IOT: return int_ot;
      IRQ: return irq;
      MAXP: return max_pwr;
      default: return samp;
    endcase
  endfunction : sig

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wait_for(input int w, input logic lvl, input int max, output int cnt);
    logic ok;
    cnt = 0;
    do begin
      @(negedge hclk);
      cnt++;
      ok = (sig(w) === lvl);
    end while (!ok && cnt < max);
    @(posedge hclk);
    check($sformatf("wait on output %0d", w), 32'(ok), 32'h1);
    if (!ok) final_report();
  endtask : wait_for

  task automatic hold(input int w, input logic lvl, input int cyc);
    logic bad;
    bad = 1'b0;
    repeat (cyc) begin
      @(negedge hclk);
      if (sig(w) !== lvl) bad = 1'b1;
    end
    @(posedge hclk);
    check($sformatf("steady output %0d", w), 32'(bad), 32'h0);
  endtask : hold

  task automatic ready_wait(output logic [31:0] d);
    logic r;
    int k;
    k = 0;
    do begin
      @(negedge hclk);
      r = hreadyout;
      d = hrdata;
      @(posedge hclk);
      k++;
    end while (r !== 1'b1 && k < 20);
    check("bus ready", 32'(r), 32'h1);
    if (r !== 1'b1) final_report();
  endtask : ready_wait

  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    ready_wait(d);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    ready_wait(d);
    check("bus response", 32'(hresp), 32'h0);
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    bus(a, 1'b1, wd, rd);
  endtask : wr

  task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    bus(a, 1'b0, 32'h0, rd);
    check(what, rd, exp);
  endtask : rdchk

  task automatic do_reset(input logic [7:0] c);
    code <= c;
    flt <= 6'h00;
    vdiff <= 1'b0;
    hot <= 1'b0;
    gate <= 1'b0;
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    check("overtemp in reset", 32'(ext_ot), 32'h1);
    check("stage2 in reset", 32'(stage2_en), 32'h0);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask : do_reset

  task automatic fire(input int src);
    gate <= 1'b1;
    flt[src] <= 1'b1;
    @(posedge hclk);
    gate <= 1'b0;
  endtask : fire

  initial begin
    regs = '{'{ba(protection_fault_pkg::IDX_LATCH_CFG), 32'hFFFFFFFF, 32'h03},
             '{ba(protection_fault_pkg::IDX_WAKE_CFG), 32'hFFFFFFFF, 32'h0F},
             '{ba(protection_fault_pkg::IDX_DISABLE_CFG), 32'hFFFFFFFF, 32'hFF},
             '{ba(protection_fault_pkg::IDX_BLANK_CFG), 32'h000000A5, 32'hA5},
             '{protection_fault_pkg::ADDR_RESTART, 32'hFFFFFFFF, 32'hFE},
             '{protection_fault_pkg::ADDR_MASK, 32'hFFFFFFFF, 32'h1F},
             '{12'h300, 32'hFFFFFFFF, 32'h00}};
    frows = '{'{0, 8'h00, 37, 43, 1'b0}, '{0, 8'hF0, 224, 230, 1'b0},
              '{1, 8'h00, 249, 255, 1'b0}, '{1, 8'h0E, 1124, 1130, 1'b0},
              '{2, 8'h00, 1, 5, 1'b0}, '{3, 8'h00, 1, 5, 1'b1},
              '{4, 8'h00, 1, 5, 1'b1}, '{5, 8'h00, 1, 5, 1'b1}};
    do_reset(8'h40);
    hold(EOT, 1'b1, 10);
    foreach (regs[i]) rdchk("reset value", regs[i].a, 32'h0);
    wr(ba(protection_fault_pkg::IDX_WAKE_CFG), 32'h01);
    hold(EOT, 1'b1, 10);
    wr(ba(protection_fault_pkg::IDX_WAKE_CFG), 32'h02);
    wait_for(EOT, 1'b0, 5, n);
    $display("power-up test done");
    wr(protection_fault_pkg::ADDR_MASK, 32'h04);
    code <= 8'h54;
    hold(EOT, 1'b0, 5);
    code <= 8'h55;
    wait_for(EOT, 1'b1, 5, n);
    wait_for(IRQ, 1'b1, 3, n);
    wr(ba(protection_fault_pkg::IDX_DISABLE_CFG), 32'h02);
    wait_for(EOT, 1'b0, 5, n);
    wr(ba(protection_fault_pkg::IDX_DISABLE_CFG), 32'h00);
    wait_for(EOT, 1'b1, 5, n);
    code <= 8'h43;
    wait_for(EOT, 1'b0, 5, n);
    bus(protection_fault_pkg::ADDR_STATUS, 1'b0, 32'h0, rd);
    check("status bit", rd & 32'h04, 32'h04);
    wr(protection_fault_pkg::ADDR_STATUS, 32'h04);
    wait_for(IRQ, 1'b0, 3, n);
    $display("shutdown test done");
    code <= 8'h48;
    wr(ba(protection_fault_pkg::IDX_DISABLE_CFG), 32'h01);
    hot <= 1'b1;
    hold(IOT, 1'b0, 40);
    wait_for(SMP, 1'b1, 40, n);
    wait_for(SMP, 1'b1, 40, n);
    check("fast sample gap", n, 16);
    wr(ba(protection_fault_pkg::IDX_BLANK_CFG), 32'h01);
    wait_for(SMP, 1'b1, 40, n);
    wait_for(SMP, 1'b1, 40, n);
    check("slow sample gap", n, 32);
    wr(ba(protection_fault_pkg::IDX_DISABLE_CFG), 32'h00);
    wait_for(IOT, 1'b1, 40, n);
    wait_for(SMP, 1'b1, 40, n);
    wait_for(SMP, 1'b1, 40, n);
    check("in-fault sample gap", n, 16);
    code <= 8'h40;
    wait_for(IOT, 1'b0, 5, n);
    hot <= 1'b0;
    flt[3] <= 1'b1;
    hold(MAXP, 1'b0, 10);
    wr(ba(protection_fault_pkg::IDX_LATCH_CFG), 32'h01);
    wait_for(MAXP, 1'b1, 5, n);
    $display("temperature and power test done");
    do_reset(8'h00);
    wait_for(S2, 1'b1, 10, n);
    for (int i = 0; i < 2; i++) begin
      wr(protection_fault_pkg::ADDR_RESTART, i ? 32'h0A : 32'h08);
      vdiff <= 1'b1;
      @(posedge hclk);
      vdiff <= 1'b0;
      wait_for(S2, 1'b0, 5, n);
      wait_for(S2, 1'b1, 45, n);
      check("restart delay", 32'(n >= 15 + 16 * i && n <= 20 + 16 * i), 32'h1);
    end
    wr(ba(protection_fault_pkg::IDX_LATCH_CFG), 32'h02);
    vdiff <= 1'b1;
    @(posedge hclk);
    vdiff <= 1'b0;
    wait_for(S2, 1'b0, 5, n);
    hold(S2, 1'b0, 100);
    bus(protection_fault_pkg::ADDR_STATE, 1'b0, 32'h0, rd);
    check("latched state", {29'h0, rd[5:3]}, 32'h4);
    $display("restart and latch test done");
    foreach (regs[i]) begin
      wr(regs[i].a, regs[i].wd);
      rdchk("register readback", regs[i].a, regs[i].exp);
    end
    foreach (frows[i]) begin
      do_reset(8'h00);
      wait_for(frows[i].bst, 1'b1, 10, n);
      wr(ba(protection_fault_pkg::IDX_BLANK_CFG), {24'h0, frows[i].blank});
      wr(ba(protection_fault_pkg::IDX_DISABLE_CFG), 32'h80 >> frows[i].src);
      fire(frows[i].src);
      hold(frows[i].bst, 1'b1, frows[i].hi + 5);
      flt <= 6'h00;
      wr(ba(protection_fault_pkg::IDX_DISABLE_CFG), 32'h00);
      fire(frows[i].src);
      wait_for(frows[i].bst, 1'b0, frows[i].hi + 5, n);
      check("fault delay", 32'(n >= frows[i].lo && n <= frows[i].hi), 32'h1);
    end
    $display("protection row test done");
    final_report();
  end
endmodule : protection_fault_config_tb
